// [eecfg_defs.svh]
// eecfg constants: locations, field positions, reset values, timing
`ifndef EECFG_DEFS_SVH
`define EECFG_DEFS_SVH

// ****************************************
// eeprom addressing
// ****************************************
`define EECFG_DEV_ADDR 7'h50
`define EECFG_MEM_SIZE 8'h40
`define EECFG_LAST_LOC 6'h3f

// ****************************************
// protected ranges and checksum locations
// ****************************************
`define EECFG_C16_HI0 6'h20
`define EECFG_C16_LO1 6'h30
`define EECFG_C8_LO 6'h23
`define EECFG_C8_HI 6'h2e
`define EECFG_LOC_C16L 6'h22
`define EECFG_LOC_C16H 6'h21
`define EECFG_LOC_C8 6'h2f
`define EECFG_SER_C16L 8'h80
`define EECFG_SER_C16H 8'h81
`define EECFG_SER_C8 8'h82
`define EECFG_POLY16 16'h1021
`define EECFG_POLY8 8'h97
`define EECFG_INIT16 16'h0001
`define EECFG_INIT8 8'h01

// ****************************************
// configuration fields and defaults
// ****************************************
`define EECFG_LOC_MODE 6'h0b
`define EECFG_LOC_CHK 6'h0d
`define EECFG_NCHK_BIT 6
`define EECFG_MODE_BISS 8'h02
`define EECFG_MODE_SPI 8'h00
`define EECFG_TRIES 2'd3

// ****************************************
// timing
// ****************************************
`define EECFG_SCL_KHZ 70
`define EECFG_LINK_KHZ 166667
`define EECFG_QTR_CYC ((`EECFG_LINK_KHZ+4*`EECFG_SCL_KHZ-1)/(4*`EECFG_SCL_KHZ))
`define EECFG_SYS_KHZ 50000
`define EECFG_WR_US 5000
`define EECFG_CYC_US 1000

`endif

// [eecfg_pkg.sv]
// eecfg shared types
package eecfg_pkg;
   typedef enum logic [3:0] {
      S_LREQ = 4'b0000, S_LWAIT = 4'b0001, S_LCHK = 4'b0010,
      S_DFLT = 4'b0011, S_RUN = 4'b0100, S_VSCAN = 4'b0101,
      S_VCHK = 4'b0110, S_SSCAN = 4'b0111, S_SPUT = 4'b1000,
      S_SREQ = 4'b1001, S_SWAIT = 4'b1010, S_SDLY = 4'b1011
   } eecfg_seq_t;
   typedef enum logic [2:0] {
      L_IDLE = 3'b000, L_FREE = 3'b001, L_START = 3'b010,
      L_BIT = 3'b011, L_STOP = 3'b100
   } eecfg_link_t;
endpackage

// [eecfg_i2c.sv]
// eecfg link side: one-byte i2c transfers on the link clock
`timescale 1ns/1ns
`include "eecfg_defs.svh"
module eecfg_i2c #(
   parameter int QTR_CYC = `EECFG_QTR_CYC
) (
   // clock and reset
   input wire logic clk_link,
   input wire logic rst,
   // request, stable while req_tgl differs from ack_tgl
   input wire logic req_tgl,
   input wire logic op_wr,
   input wire logic [10:0] loc,
   input wire logic [7:0] wdata,
   // answer, valid when ack_tgl toggles
   output logic ack_tgl,
   output logic [7:0] rdata,
   output logic fault,
   // open-drain bus
   input wire logic scl_in,
   input wire logic sda_in,
   output logic scl_oe,
   output logic sda_oe
);
   eecfg_pkg::eecfg_link_t st_reg;
   logic [1:0] rs_reg, rq_reg, scl_reg, sda_reg, q_reg, byte_reg;
   logic seen_reg;
   logic [9:0] div_reg;
   logic [3:0] bit_reg;
   logic [8:0] sh_reg;
   wire [6:0] dev = `EECFG_DEV_ADDR;

   // address byte holds block bits, then word byte, then data (write) or the read address byte
   function automatic logic [8:0] frame(input logic [1:0] idx);
      logic [7:0] b;
      b = 8'hff;
      if (idx == 2'd0) b = {dev[6:3], loc[10:8], 1'b0};
      if (idx == 2'd1) b = loc[7:0];
      if (idx == 2'd2) b = op_wr ? wdata : {dev[6:3], loc[10:8], 1'b1};
      return {b, 1'b1};
   endfunction

   wire rst_l = rs_reg[1];
   wire scl_s = scl_reg[1];
   wire sda_s = sda_reg[1];
   wire tick = div_reg == 10'(QTR_CYC - 1);
   wire go = tick && !(q_reg == 2'd2 && !scl_s);
   wire is_rd = byte_reg == 2'd3;
   wire last = op_wr ? byte_reg == 2'd2 : is_rd;

   always_ff @(posedge clk_link) begin
      rs_reg <= {rs_reg[0], rst};
      rq_reg <= {rq_reg[0], req_tgl};
      scl_reg <= {scl_reg[0], scl_in};
      sda_reg <= {sda_reg[0], sda_in};
   end

   always_ff @(posedge clk_link) begin
      if (rst_l) begin
         st_reg <= eecfg_pkg::L_IDLE;
         {seen_reg, ack_tgl, fault, scl_oe, sda_oe} <= 5'h00;
         rdata <= 8'h00;
         div_reg <= 10'h000;
         {q_reg, byte_reg, bit_reg} <= 8'h00;
         sh_reg <= 9'h1ff;
      end else begin
         div_reg <= tick ? 10'h000 : div_reg + 10'h001;
         if (go) q_reg <= q_reg + 2'h1;
         unique case (st_reg)
         eecfg_pkg::L_IDLE: if (rq_reg[1] != seen_reg) begin
            seen_reg <= rq_reg[1];
            fault <= 1'b0;
            bit_reg <= 4'h0;
            st_reg <= eecfg_pkg::L_FREE;
         end
         eecfg_pkg::L_FREE: if (tick) begin
            bit_reg <= (scl_s && sda_s) ? bit_reg + 4'h1 : 4'h0;
            q_reg <= 2'h0;
            byte_reg <= 2'h0;
            if (bit_reg == 4'h7) st_reg <= eecfg_pkg::L_START;
         end
         eecfg_pkg::L_START: if (go) begin
            unique case (q_reg)
            2'h0: sda_oe <= 1'b0;
            2'h1: scl_oe <= 1'b0;
            2'h2: sda_oe <= 1'b1;
            2'h3: begin
               scl_oe <= 1'b1;
               bit_reg <= 4'h0;
               sh_reg <= frame(byte_reg);
               st_reg <= eecfg_pkg::L_BIT;
            end
            endcase
         end
         eecfg_pkg::L_BIT: if (go) begin
            unique case (q_reg)
            2'h0: sda_oe <= !sh_reg[8];
            2'h1: scl_oe <= 1'b0;
            2'h2: begin
               if (bit_reg == 4'h8) begin
                  fault <= sda_s && !is_rd;
               end else if (is_rd) begin
                  rdata <= {rdata[6:0], sda_s};
               end else if (sh_reg[8] && !sda_s) begin
                  {sda_oe, scl_oe} <= 2'h0;
                  bit_reg <= 4'h0;
                  st_reg <= eecfg_pkg::L_FREE;
               end
            end
            2'h3: begin
               scl_oe <= 1'b1;
               sh_reg <= {sh_reg[7:0], 1'b1};
               bit_reg <= bit_reg + 4'h1;
               if (bit_reg == 4'h8) begin
                  bit_reg <= 4'h0;
                  if (fault || last) begin
                     st_reg <= eecfg_pkg::L_STOP;
                  end else if (!op_wr && byte_reg == 2'h1) begin
                     byte_reg <= 2'h2;
                     st_reg <= eecfg_pkg::L_START;
                  end else begin
                     byte_reg <= byte_reg + 2'h1;
                     sh_reg <= frame(byte_reg + 2'h1);
                  end
               end
            end
            endcase
         end
         eecfg_pkg::L_STOP: if (go) begin
            unique case (q_reg)
            2'h0: sda_oe <= 1'b1;
            2'h1: scl_oe <= 1'b0;
            2'h2: sda_oe <= 1'b0;
            2'h3: begin
               ack_tgl <= !ack_tgl;
               st_reg <= eecfg_pkg::L_IDLE;
            end
            endcase
         end
         default: st_reg <= eecfg_pkg::L_IDLE;
         endcase
      end
   end
endmodule

// [eecfg_loader.sv]
// eecfg loader: eeprom configuration load, checksums, store
`timescale 1ns/1ns
`include "eecfg_defs.svh"
module eecfg_loader #(
   parameter int WR_CYC = `EECFG_WR_US * `EECFG_SYS_KHZ / 1000,
   parameter int CYC_CYC = `EECFG_CYC_US * `EECFG_SYS_KHZ / 1000,
   parameter int QTR_CYC = `EECFG_QTR_CYC
) (
   // clocks and reset
   input wire logic clk_sys,
   input wire logic rst,
   input wire logic clk_link,
   // serial register access
   input wire logic spi_mode,
   input wire logic [7:0] reg_addr,
   input wire logic reg_wr,
   input wire logic [7:0] reg_wdata,
   output logic [7:0] reg_rdata,
   // commands and pins
   input wire logic verify_checksum_command,
   input wire logic store_command,
   input wire logic status_clear,
   input wire logic default_interface_pin,
   // status
   output logic [2:0] port_a_function_select,
   output logic checksum_error,
   output logic eeprom_error,
   output logic defaults_active,
   output logic config_ready,
   output logic busy,
   // eeprom bus
   input wire logic scl_in,
   input wire logic sda_in,
   output logic scl_out,
   output logic sda_out,
   output logic scl_oe,
   output logic sda_oe
);
   // ****************************************
   // state
   // ****************************************
   eecfg_pkg::eecfg_seq_t st_reg;
   logic [7:0] cfg_mem [0:63];
   logic [5:0] scan_reg;
   logic [15:0] c16_reg;
   logic [7:0] c8_reg, wdata_reg;
   logic [1:0] tries_reg, ack_sync_reg, pin_sync_reg;
   logic [17:0] dly_reg, cyc_reg;
   logic req_reg, op_wr_reg, ack_seen_reg, dflt_reg, ready_reg;
   logic link_ack, link_fault;
   logic [7:0] link_rdata;

   // ****************************************
   // checksum arithmetic
   // ****************************************
   function automatic logic [15:0] crc16_byte(input logic [15:0] c,
                                              input logic [7:0] d);
      logic [15:0] r;
      r = c;
      for (int i = 7; i >= 0; i--) begin
         r = {r[14:0], 1'b0} ^ ((r[15] ^ d[i]) ? `EECFG_POLY16 : 16'h0000);
      end
      return r;
   endfunction

   function automatic logic [7:0] crc8_byte(input logic [7:0] c,
                                            input logic [7:0] d);
      logic [7:0] r;
      r = c;
      for (int i = 7; i >= 0; i--) begin
         r = {r[6:0], 1'b0} ^ ((r[7] ^ d[i]) ? `EECFG_POLY8 : 8'h00);
      end
      return r;
   endfunction

   // ****************************************
   // decode
   // ****************************************
   wire idle = st_reg == eecfg_pkg::S_RUN;
   wire ack_new = ack_sync_reg[1] != ack_seen_reg;
   wire pin_s = pin_sync_reg[1];
   wire [7:0] mem_q = cfg_mem[scan_reg];
   wire ld_ack = st_reg == eecfg_pkg::S_LWAIT && ack_new;
   wire [7:0] feed = ld_ack ? link_rdata : mem_q;
   wire in16 = scan_reg <= `EECFG_C16_HI0 ||
               scan_reg >= `EECFG_C16_LO1;
   wire in8 = scan_reg >= `EECFG_C8_LO &&
              scan_reg <= `EECFG_C8_HI;
   wire [15:0] c16_next = in16 ? crc16_byte(c16_reg, feed) : c16_reg;
   wire [7:0] c8_next = in8 ? crc8_byte(c8_reg, feed) : c8_reg;
   wire scan_end = scan_reg == `EECFG_LAST_LOC;
   wire [15:0] c16_stored = {cfg_mem[`EECFG_LOC_C16H],
                             cfg_mem[`EECFG_LOC_C16L]};
   wire crc_ok = c16_reg == c16_stored &&
                 c8_reg == cfg_mem[`EECFG_LOC_C8];
   wire nchk = cfg_mem[`EECFG_LOC_CHK][`EECFG_NCHK_BIT];
   wire cyc_due = cyc_reg == 18'(CYC_CYC - 1);
   wire dly_done = dly_reg == 18'(WR_CYC - 1);

   // serial register window
   wire ser_l = reg_addr == `EECFG_SER_C16L;
   wire ser_h = reg_addr == `EECFG_SER_C16H;
   wire ser_8 = reg_addr == `EECFG_SER_C8;
   wire ser_crc = spi_mode && (ser_l || ser_h || ser_8);
   wire [5:0] ser_loc = ser_l ? `EECFG_LOC_C16L :
                        ser_h ? `EECFG_LOC_C16H : `EECFG_LOC_C8;
   wire host_mem = reg_addr < `EECFG_MEM_SIZE;
   wire host_we = idle && reg_wr && (host_mem || ser_crc);
   wire [5:0] host_wa = host_mem ? reg_addr[5:0] : ser_loc;
   wire [7:0] rd_next = host_mem ? cfg_mem[reg_addr[5:0]] :
                        ser_crc ? cfg_mem[ser_loc] : 8'h00;

   // checksum write-back during store, default fill
   wire [5:0] put_loc = scan_reg == 6'h00 ? `EECFG_LOC_C16L :
                        scan_reg == 6'h01 ? `EECFG_LOC_C16H :
                        `EECFG_LOC_C8;
   wire [7:0] put_val = scan_reg == 6'h00 ? c16_reg[7:0] :
                        scan_reg == 6'h01 ? c16_reg[15:8] : c8_reg;
   wire [7:0] dflt_val = scan_reg != `EECFG_LOC_MODE ? 8'h00 :
                         pin_s ? `EECFG_MODE_SPI : `EECFG_MODE_BISS;

   // memory write port
   wire in_put = st_reg == eecfg_pkg::S_SPUT;
   wire in_dflt = st_reg == eecfg_pkg::S_DFLT;
   wire mem_we = (ld_ack && !link_fault) || in_dflt || in_put || host_we;
   wire [5:0] mem_wa = in_put ? put_loc : idle ? host_wa : scan_reg;
   wire [7:0] mem_wd = in_put ? put_val : in_dflt ? dflt_val :
                       idle ? reg_wdata : link_rdata;

   // error events
   wire chk_state = st_reg == eecfg_pkg::S_LCHK ||
                    st_reg == eecfg_pkg::S_VCHK;
   wire crc_set = chk_state && !crc_ok;
   wire st_ack = st_reg == eecfg_pkg::S_SWAIT && ack_new;
   wire epr_set = (ld_ack || st_ack) && link_fault;
   wire fail = (ld_ack && link_fault) ||
               (st_reg == eecfg_pkg::S_LCHK && !crc_ok);
   wire last_try = tries_reg == `EECFG_TRIES - 2'd1;

   // ****************************************
   // link side
   // ****************************************
   eecfg_i2c #(.QTR_CYC(QTR_CYC)) u_link (
      .clk_link(clk_link),
      .rst(rst),
      .req_tgl(req_reg),
      .op_wr(op_wr_reg),
      .loc({5'h00, scan_reg}),
      .wdata(wdata_reg),
      .ack_tgl(link_ack),
      .rdata(link_rdata),
      .fault(link_fault),
      .scl_in(scl_in),
      .sda_in(sda_in),
      .scl_oe(scl_oe),
      .sda_oe(sda_oe)
   );

   assign scl_out = 1'b0;
   assign sda_out = 1'b0;

   always_ff @(posedge clk_sys) begin
      ack_sync_reg <= {ack_sync_reg[0], link_ack};
      pin_sync_reg <= {pin_sync_reg[0], default_interface_pin};
   end

   always_ff @(posedge clk_sys) begin
      if (mem_we) cfg_mem[mem_wa] <= mem_wd;
   end

   // ****************************************
   // sequencer
   // ****************************************
   always_ff @(posedge clk_sys) begin
      if (rst) begin
         st_reg <= eecfg_pkg::S_LREQ;
         scan_reg <= 6'h00;
         c16_reg <= `EECFG_INIT16;
         c8_reg <= `EECFG_INIT8;
         tries_reg <= 2'h0;
         {req_reg, op_wr_reg, dflt_reg, ready_reg} <= 4'h0;
         wdata_reg <= 8'h00;
         dly_reg <= 18'h00000;
         cyc_reg <= 18'h00000;
      end else begin
         unique case (st_reg)
         eecfg_pkg::S_LREQ: begin
            req_reg <= !req_reg;
            op_wr_reg <= 1'b0;
            st_reg <= eecfg_pkg::S_LWAIT;
         end
         eecfg_pkg::S_LWAIT: if (ack_new) begin
            c16_reg <= c16_next;
            c8_reg <= c8_next;
            scan_reg <= scan_reg + 6'h01;
            st_reg <= scan_end ? eecfg_pkg::S_LCHK : eecfg_pkg::S_LREQ;
         end
         eecfg_pkg::S_LCHK: begin
            ready_reg <= crc_ok;
            st_reg <= eecfg_pkg::S_RUN;
         end
         eecfg_pkg::S_DFLT: begin
            scan_reg <= scan_reg + 6'h01;
            if (scan_end) begin
               dflt_reg <= 1'b1;
               ready_reg <= 1'b1;
               st_reg <= eecfg_pkg::S_RUN;
            end
         end
         eecfg_pkg::S_RUN: begin
            cyc_reg <= (nchk || dflt_reg) ? 18'h00000 : cyc_reg + 18'h1;
            c16_reg <= `EECFG_INIT16;
            c8_reg <= `EECFG_INIT8;
            scan_reg <= 6'h00;
            if (store_command) begin
               st_reg <= eecfg_pkg::S_SSCAN;
            end else if (verify_checksum_command || cyc_due) begin
               cyc_reg <= 18'h00000;
               st_reg <= eecfg_pkg::S_VSCAN;
            end
         end
         eecfg_pkg::S_VSCAN, eecfg_pkg::S_SSCAN: begin
            c16_reg <= c16_next;
            c8_reg <= c8_next;
            scan_reg <= scan_reg + 6'h01;
            if (scan_end) begin
               st_reg <= st_reg == eecfg_pkg::S_VSCAN ?
                         eecfg_pkg::S_VCHK : eecfg_pkg::S_SPUT;
            end
         end
         eecfg_pkg::S_VCHK: st_reg <= eecfg_pkg::S_RUN;
         eecfg_pkg::S_SPUT: begin
            scan_reg <= scan_reg + 6'h01;
            if (scan_reg == 6'h02) begin
               scan_reg <= 6'h00;
               st_reg <= eecfg_pkg::S_SREQ;
            end
         end
         eecfg_pkg::S_SREQ: begin
            req_reg <= !req_reg;
            op_wr_reg <= 1'b1;
            wdata_reg <= mem_q;
            st_reg <= eecfg_pkg::S_SWAIT;
         end
         eecfg_pkg::S_SWAIT: if (ack_new) begin
            dly_reg <= 18'h00000;
            st_reg <= link_fault ? eecfg_pkg::S_RUN : eecfg_pkg::S_SDLY;
         end
         eecfg_pkg::S_SDLY: begin
            dly_reg <= dly_reg + 18'h1;
            if (dly_done) begin
               scan_reg <= scan_reg + 6'h01;
               st_reg <= scan_end ? eecfg_pkg::S_RUN : eecfg_pkg::S_SREQ;
            end
         end
         default: st_reg <= eecfg_pkg::S_LREQ;
         endcase
         if (fail) begin
            tries_reg <= tries_reg + 2'h1;
            scan_reg <= 6'h00;
            c16_reg <= `EECFG_INIT16;
            c8_reg <= `EECFG_INIT8;
            st_reg <= last_try ? eecfg_pkg::S_DFLT : eecfg_pkg::S_LREQ;
         end
      end
   end

   // ****************************************
   // handshake and status
   // ****************************************
   always_ff @(posedge clk_sys) begin
      if (rst) begin
         ack_seen_reg <= 1'b0;
      end else if (ack_new) begin
         ack_seen_reg <= ack_sync_reg[1];
      end
   end

   always_ff @(posedge clk_sys) begin
      if (rst) begin
         checksum_error <= 1'b0;
         eeprom_error <= 1'b0;
      end else begin
         checksum_error <= crc_set || (checksum_error && !status_clear);
         eeprom_error <= epr_set || (eeprom_error && !status_clear);
      end
   end

   always_ff @(posedge clk_sys) begin
      if (rst) begin
         reg_rdata <= 8'h00;
         port_a_function_select <= 3'h0;
         defaults_active <= 1'b0;
         config_ready <= 1'b0;
         busy <= 1'b1;
      end else begin
         reg_rdata <= rd_next;
         port_a_function_select <= cfg_mem[`EECFG_LOC_MODE][2:0];
         defaults_active <= dflt_reg;
         config_ready <= ready_reg;
         busy <= !idle;
      end
   end
endmodule

// [eecfg_assertions.sv]
// eecfg loader port checker
`timescale 1ns/1ns
module eecfg_assertions (
   // clock and reset
   input wire logic clk_sys,
   input wire logic rst,
   // register side
   input wire logic spi_mode,
   input wire logic [7:0] reg_addr,
   input wire logic [7:0] reg_rdata,
   input wire logic verify_checksum_command,
   input wire logic status_clear,
   // status
   input wire logic [2:0] port_a_function_select,
   input wire logic checksum_error,
   input wire logic defaults_active,
   input wire logic config_ready,
   input wire logic busy,
   // eeprom bus
   input wire logic scl_out,
   input wire logic sda_out,
   input wire logic scl_oe
);
   default clocking @(posedge clk_sys); endclocking
   default disable iff (rst);
   chk_drive_low: assert property (!scl_out && !sda_out)
      else $error("bus line driven high");
   chk_scl_slow: assert property (
      $changed(scl_oe) |=> $stable(scl_oe) [*8])
      else $error("serial clock too fast");
   chk_spi_gate: assert property (
      !spi_mode && reg_addr inside {8'h80, 8'h81, 8'h82}
      |=> reg_rdata == 8'h00) else $error("checksum read outside spi");
   chk_verify_busy: assert property (
      verify_checksum_command && !busy |-> ##[1:3] busy)
      else $error("verify command ignored");
   chk_err_sticky: assert property (
      checksum_error && !status_clear |=> checksum_error)
      else $error("checksum error lost");
   chk_ready_hold: assert property (config_ready |=> config_ready)
      else $error("ready dropped");
   chk_run_loaded: assert property (!busy |-> config_ready)
      else $error("running before load");
   chk_dflt_ready: assert property (
      defaults_active |-> config_ready) else $error("defaults not ready");
   chk_dflt_mode: assert property (
      $rose(defaults_active) |-> ##[0:2]
      port_a_function_select inside {3'h0, 3'h2})
      else $error("default interface wrong");
   cover property ($rose(config_ready));
   cover property ($rose(checksum_error) && config_ready);
   cover property (verify_checksum_command && !busy);
endmodule

// [eecfg_eeprom_model.sv]
// serial eeprom partner with one address byte and block bits
`timescale 1ns/1ns
module eecfg_eeprom_model (
   // bus levels
   input wire logic scl,
   input wire logic sda,
   // open-drain pull of data line
   output logic sda_pull
);
   logic [7:0] mem [0:2047];
   logic [7:0] sh = 8'h00;
   logic [10:0] ptr = 11'h000;
   logic [2:0] blk = 3'h0;
   int n = 0;
   int st = 0;
   initial sda_pull = 1'b0;
   // start and stop framing
   always @(negedge sda) if (scl) begin
      st = 1;
      n = 0;
   end
   always @(posedge sda) if (scl) st = 0;
   always @(posedge scl) begin
      if (n < 8) begin
         sh = {sh[6:0], sda};
         n = n + 1;
      end else begin
         n = 0;
         if (st == 5) st = 4;
         else if (st == 4) begin
            ptr = ptr + 11'h001;
            if (sda) st = 0;
         end
      end
   end
   always @(negedge scl) begin
      sda_pull = 1'b0;
      if (n == 8 && st == 1) begin
         st = 0;
         if (sh[7:4] == 4'ha) begin
            blk = sh[3:1];
            st = sh[0] ? 5 : 2;
            sda_pull = 1'b1;
         end
      end else if (n == 8 && st == 2) begin
         ptr = {blk, sh};
         st = 3;
         sda_pull = 1'b1;
      end else if (n == 8 && st == 3) begin
         mem[ptr] = sh;
         ptr = ptr + 11'h001;
         sda_pull = 1'b1;
      end else if (st == 4 && n < 8)
         sda_pull = !mem[ptr][7 - n];
   end
endmodule

// [eecfg_loader_bench.sv]
// eecfg loader bench: eeprom load, register access, checksums
`timescale 1ns/1ns
module eecfg_loader_bench;
   localparam int CYC = 400;
   logic clk_sys = 1'b0;
   logic clk_link = 1'b0;
   logic rst = 1'b1;
   logic spi_mode = 1'b0;
   logic [7:0] reg_addr = 8'h00;
   logic reg_wr = 1'b0;
   logic [7:0] reg_wdata = 8'h00;
   logic verify_checksum_command = 1'b0;
   logic status_clear = 1'b0;
   logic store_command = 1'b0, pin = 1'b0, eep_off = 1'b0;
   logic [7:0] reg_rdata;
   logic [2:0] port_a_function_select;
   logic checksum_error, eeprom_error, defaults_active, config_ready, busy;
   logic scl_out, sda_out, scl_oe, sda_oe, eep_pull, scl_bus, sda_bus;
   logic [7:0] img [0:63];
   logic [7:0] v;
   int failures = 0;
   int checks_done = 0;
   int lst [4] = '{'h21, 'h22, 'h2e, 'h2f};
   assign scl_bus = !scl_oe;
   assign sda_bus = !(sda_oe || (eep_pull && !eep_off));
   always #10 clk_sys = !clk_sys;
   initial begin
      #2;
      forever #3 clk_link = !clk_link;
   end
   eecfg_loader #(.WR_CYC(20), .CYC_CYC(CYC), .QTR_CYC(16)) u_eecfg_loader (
      .clk_sys, .rst, .clk_link, .spi_mode, .reg_addr, .reg_wr,
      .reg_wdata, .reg_rdata, .verify_checksum_command,
      .store_command, .status_clear, .default_interface_pin(pin),
      .port_a_function_select, .checksum_error, .eeprom_error,
      .defaults_active, .config_ready, .busy, .scl_in(scl_bus),
      .sda_in(sda_bus), .scl_out, .sda_out, .scl_oe, .sda_oe);
   eecfg_eeprom_model u_eecfg_eeprom_model (.scl(scl_bus),
      .sda(sda_bus), .sda_pull(eep_pull));
   task automatic check(input logic [15:0] seen, input logic [15:0] exp);
      checks_done++;
      if (seen !== exp) begin
         failures++;
         $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask
   task automatic conclude();
      $display("checks %0d failures %0d", checks_done, failures);
      if (failures == 0 && checks_done > 0)
         $display("verification passed");
      else
         $display("verification failed");
      $finish;
   endtask
   task automatic await(ref logic s, input logic val, input int lim);
      int n;
      n = 0;
      while (s !== val && n < lim) begin
         @(posedge clk_sys);
         #1 n++;
      end
      check(s, val);
   endtask
   task automatic rd(input logic [7:0] a);
      @(posedge clk_sys) reg_addr <= a;
      @(posedge clk_sys);
      @(posedge clk_sys);
      #1 v = reg_rdata;
   endtask
   // retried, since a cyclic check may refuse it
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      v = ~d;
      for (int i = 0; i < 4 && v !== d; i++) begin
         await(busy, 1'b0, 200);
         @(posedge clk_sys);
         reg_addr <= a;
         reg_wdata <= d;
         reg_wr <= 1'b1;
         @(posedge clk_sys) reg_wr <= 1'b0;
         rd(a);
      end
   endtask
   task automatic clr();
      await(busy, 1'b0, 200);
      @(posedge clk_sys) status_clear <= 1'b1;
      @(posedge clk_sys) status_clear <= 1'b0;
   endtask
   // save selects the store command instead of verify
   task automatic vfy(input logic save);
      await(busy, 1'b0, 200);
      @(posedge clk_sys) begin
         verify_checksum_command <= !save;
         store_command <= save;
      end
      @(posedge clk_sys) {verify_checksum_command, store_command} <= 2'h0;
      await(busy, 1'b1, 4);
      await(busy, 1'b0, 1000);
   endtask
   // expected checksums placed into the image
   function automatic void seal();
      logic [15:0] c16;
      logic [7:0] c8;
      c16 = 16'h0001;
      c8 = 8'h01;
      for (int a = 0; a < 64; a++)
         for (int b = 7; b >= 0; b--) begin
            if (a <= 'h20 || a >= 'h30)
               c16 = {c16[14:0], 1'b0}
                  ^ (c16[15] ^ img[a][b] ? 16'h1021 : 16'h0000);
            if (a >= 'h23 && a <= 'h2e)
               c8 = {c8[6:0], 1'b0} ^ (c8[7] ^ img[a][b] ? 8'h97 : 8'h00);
         end
      img['h21] = c16[15:8];
      img['h22] = c16[7:0];
      img['h2f] = c8;
   endfunction
   initial begin
      #4000000;
      failures++;
      conclude();
   end
   initial begin
      for (int i = 0; i < 64; i++)
         img[i] = 8'(i * 29) ^ 8'ha5;
      img['h0b] = 8'h05;
      img['h0d] = 8'h00;
      seal();
      for (int i = 0; i < 64; i++)
         u_eecfg_eeprom_model.mem[i] = img[i];
      u_eecfg_eeprom_model.mem['h30] = ~img['h30];
      repeat (20) @(posedge clk_sys);
      check(busy, 1'b1);
      rst <= 1'b0;
      await(checksum_error, 1'b1, 80000);
      check(config_ready, 1'b0);
      u_eecfg_eeprom_model.mem['h30] = img['h30];
      await(config_ready, 1'b1, 80000);
      check(defaults_active, 1'b0);
      check(port_a_function_select, 3'h5);
      clr();
      repeat (2 * CYC) @(posedge clk_sys);
      check(checksum_error, 1'b0);
      for (int i = 0; i < 64; i++) begin
         rd(8'(i));
         check(v, img[i]);
      end
      for (int i = 0; i < 4; i++) begin
         rd(i < 3 ? 8'h80 + 8'(i) : 8'h60);
         check(v, 8'h00);
      end
      @(posedge clk_sys) spi_mode <= 1'b1;
      for (int i = 0; i < 3; i++) begin
         rd(8'h80 + 8'(i));
         check(v, img[i == 2 ? 'h2f : 'h22 - i]);
      end
      wr(8'h0d, 8'h40);
      clr();
      repeat (2 * CYC) @(posedge clk_sys);
      check(checksum_error, 1'b0);
      vfy(1'b0);
      check(checksum_error, 1'b1);
      img['h0d] = 8'h40;
      img['h2e] = ~img['h2e];
      seal();
      foreach (lst[k]) wr(8'(lst[k]), img[lst[k]]);
      clr();
      vfy(1'b0);
      check(checksum_error, 1'b0);
      // store with a silent eeprom: checksums land in the image first
      img['h05] = 8'h3c;
      img['h24] = 8'hc3;
      wr(8'h05, img['h05]);
      wr(8'h24, img['h24]);
      seal();
      @(posedge clk_sys) eep_off <= 1'b1;
      vfy(1'b1);
      check(eeprom_error, 1'b1);
      foreach (lst[k]) begin
         rd(8'(lst[k]));
         check(v, img[lst[k]]);
      end
      clr();
      vfy(1'b0);
      check(checksum_error, 1'b0);
      wr(8'h0d, 8'h00);
      await(checksum_error, 1'b1, 3 * CYC);
      // mid-run resets with no eeprom answer: three faults, then defaults
      for (int p = 0; p < 2; p++) begin
         @(posedge clk_sys) rst <= 1'b1;
         pin <= p[0];
         repeat (4) @(posedge clk_sys);
         check(busy, 1'b1);
         check(defaults_active, 1'b0);
         rst <= 1'b0;
         await(defaults_active, 1'b1, 3000);
         check(config_ready, 1'b1);
         check(eeprom_error, 1'b1);
         check(port_a_function_select, p ? 3'h0 : 3'h2);
      end
      conclude();
   end
endmodule
bind eecfg_loader eecfg_assertions u_eecfg_assertions (.clk_sys, .rst,
   .spi_mode, .reg_addr, .reg_rdata, .verify_checksum_command,
   .status_clear, .port_a_function_select, .checksum_error,
   .defaults_active, .config_ready, .busy, .scl_out, .sda_out, .scl_oe);
